// File: dd_consts.svh
`ifndef DD_CONSTS_SVH
`define DD_CONSTS_SVH

`define DD_ADDR_CTRL0 4'h0
`define DD_ADDR_CTRL1 4'h1
`define DD_CTRL0_RESET 16'h0000
`define DD_CTRL1_RESET 16'h0000
`define DD_CTRL0_WMASK 16'hFFF1
`define DD_CTRL1_WMASK 16'hFFFE
`define DD_MODE_BIT 0
`define DD_LAMP_A_MSB 15
`define DD_LAMP_A_LSB 14
`define DD_LAMP_B_MSB 13
`define DD_LAMP_B_LSB 12
`define DD_LAMP9_BIT 11
`define DD_LAMP10_BIT 10
`define DD_LAMP11_BIT 9
`define DD_PULLDOWN_BIT 8
`define DD_DAC_MSB 7
`define DD_DAC_LSB 2
`define DD_MIRROR_EN_BIT 1
`define DD_PWM_B_CHANNEL 4
`define DD_FULL_MV 17'h005DC
`define DD_CLAMP_MV 11'h4B0
`define DD_CLK_PERIOD_NS 50
`define DD_STARTUP_NS 100000
`define DD_STARTUP_CYC \
  ((`DD_STARTUP_NS + `DD_CLK_PERIOD_NS - 1) / `DD_CLK_PERIOD_NS)

`endif

// File: dd_pkg.sv
package dd_pkg;
  typedef struct packed {
    logic [5:0] high_side_on;
    logic [5:0] low_side_on;
  } dd_hb_drive_t;

  typedef struct packed {
    logic [4:0] lamp_on;
    logic lamp_a_bulb;
    logic lamp_b_bulb;
  } dd_lamp_drive_t;

  typedef struct packed {
    logic pass_transistor_drive;
    logic pulldown_on;
    logic [10:0] ref_mv;
  } dd_mirror_t;

  typedef enum logic [1:0] {ST_STANDBY, ST_STARTUP, ST_ACTIVE} dd_state_t;
endpackage

// File: dd_half_bridge.sv
`include "dd_consts.svh"
module dd_half_bridge (
  input wire logic [5:0] high_side_enable,
  input wire logic [5:0] low_side_enable,
  input wire logic [5:0] pwm_select,
  input wire logic pwm_input_a,
  input wire logic pwm_input_b,
  input wire logic allow,
  output dd_pkg::dd_hb_drive_t drive
);
  import dd_pkg::*;

  genvar i;
  generate
    for (i = 0; i < 6; i++) begin : g_ch
      logic gate;
      // Output five follows the second pin
      assign gate = !pwm_select[i] ||
        ((i == `DD_PWM_B_CHANNEL) ? pwm_input_b : pwm_input_a);
      // Both bits equal gives high impedance, never both sides on
      assign drive.high_side_on[i] = allow && gate &&
        high_side_enable[i] && !low_side_enable[i];
      assign drive.low_side_on[i] = allow && gate &&
        low_side_enable[i] && !high_side_enable[i];
    end
  endgenerate
endmodule

// File: dd_mirror.sv
`include "dd_consts.svh"
module dd_mirror (
  input wire logic [5:0] ref_code,
  input wire logic full_scale_select,
  input wire logic mirror_controller_enable,
  input wire logic mirror_pulldown_enable,
  input wire logic pulldown_pwm_select,
  input wire logic pwm_input_a,
  input wire logic allow,
  output dd_pkg::dd_mirror_t mirror
);
  import dd_pkg::*;

  logic [16:0] product;
  logic [10:0] raw_mv;

  // Vout = 1.5 V / 64 * code, in millivolts
  assign product = `DD_FULL_MV * {11'h000, ref_code};
  assign raw_mv = product[16:6];
  assign mirror.ref_mv = (!full_scale_select && raw_mv > `DD_CLAMP_MV) ?
    `DD_CLAMP_MV : raw_mv;
  assign mirror.pass_transistor_drive = allow && mirror_controller_enable;
  assign mirror.pulldown_on = allow && mirror_pulldown_enable &&
    (ref_code == 6'h00) && (!pulldown_pwm_select || pwm_input_a);
endmodule

// File: dd_top.sv
// Summary of operation
// - Half-bridge: high bit alone drives high, low alone drives low, else off.
// - High and low side of one half-bridge are never on together.
// - Enabled half-bridge with PWM select on follows its PWM pin.
// - Writing one to the mode bit in Standby moves the device to Startup, then to Active.
// - Clearing mode enters Standby, clears registers and switches all outputs off.
// - Lamps A and B: 01 LED mode, 10 bulb mode, 00 or 11 off.
// - Lamps nine to eleven one bit each; selected lamps follow their PWM source.
// - Mirror pull-down can switch on only while reference code is zero.
// - Pull-down with PWM select on follows the first PWM pin.
// - Reference code sets mirror voltage, clamped at 1.2 V without full scale.
// - Mirror controller enable turns on the pass transistor drive.
// - Mirror controller enable forces lamp ten on.
// - Mirror voltage is 1.5 / 64 times code, up to 1476 mV at full scale (code 63).
// - Half-bridge five uses the second PWM pin, the others the first.
// - After the mode write a startup timer blocks outputs until Active; not-ready shows meanwhile.
`include "dd_consts.svh"
module dd_top (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic reg_write,
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic pwm_input_a,
  input wire logic pwm_input_b,
  input wire logic internal_pwm,
  input wire logic internal_pwm_enable,
  input wire logic [5:0] hb_pwm_select,
  input wire logic [4:0] lamp_pwm_select,
  input wire logic pulldown_pwm_select,
  input wire logic full_scale_select,
  output logic [15:0] reg_rdata,
  output dd_pkg::dd_hb_drive_t hb_drive,
  output dd_pkg::dd_lamp_drive_t lamp_drive,
  output dd_pkg::dd_mirror_t mirror_drive,
  output logic not_ready_flag
);
  import dd_pkg::*;

  localparam logic [11:0] STARTUP_CYC = 12'(`DD_STARTUP_CYC);

  logic rst_meta_reg;
  logic rst_n_reg;
  logic [15:0] ctrl0_reg;
  logic [15:0] ctrl1_reg;
  dd_state_t state_reg;
  logic [11:0] startup_reg;
  logic allow;
  logic mode_set;
  logic mode_clear;
  dd_hb_drive_t hb_next;
  dd_mirror_t mirror_next;
  dd_lamp_drive_t lamp_next;
  logic [4:0] lamp_enable;
  logic [4:0] lamp_source;
  logic [4:0] lamp_gate;

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  assign mode_set = reg_write && reg_addr == `DD_ADDR_CTRL0 &&
    reg_wdata[`DD_MODE_BIT];
  assign mode_clear = reg_write && reg_addr == `DD_ADDR_CTRL0 &&
    !reg_wdata[`DD_MODE_BIT] && ctrl0_reg[`DD_MODE_BIT];

  // Register writes
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ctrl0_reg <= `DD_CTRL0_RESET;
      ctrl1_reg <= `DD_CTRL1_RESET;
    end else if (mode_clear) begin
      ctrl0_reg <= `DD_CTRL0_RESET;
      ctrl1_reg <= `DD_CTRL1_RESET;
    end else if (reg_write && reg_addr == `DD_ADDR_CTRL0) begin
      ctrl0_reg <= reg_wdata & `DD_CTRL0_WMASK;
    end else if (reg_write && reg_addr == `DD_ADDR_CTRL1) begin
      ctrl1_reg <= reg_wdata & `DD_CTRL1_WMASK;
    end
  end

  // Read data
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      reg_rdata <= 16'h0000;
    end else begin
      case (reg_addr)
        `DD_ADDR_CTRL0: reg_rdata <= ctrl0_reg;
        `DD_ADDR_CTRL1: reg_rdata <= ctrl1_reg;
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

  // Mode and startup timer
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg <= ST_STANDBY;
      startup_reg <= 12'h000;
    end else begin
      case (state_reg)
        ST_STANDBY: begin
          if (mode_set) begin
            state_reg <= ST_STARTUP;
            startup_reg <= 12'h000;
          end
        end
        ST_STARTUP: begin
          if (mode_clear) begin
            state_reg <= ST_STANDBY;
          end else if (startup_reg == STARTUP_CYC - 12'h001) begin
            state_reg <= ST_ACTIVE;
          end else begin
            startup_reg <= startup_reg + 12'h001;
          end
        end
        ST_ACTIVE: begin
          if (mode_clear) begin
            state_reg <= ST_STANDBY;
          end
        end
        default: state_reg <= ST_STANDBY;
      endcase
    end
  end

  assign allow = state_reg == ST_ACTIVE;

  dd_half_bridge u_hb (
    .high_side_enable({ctrl0_reg[5], ctrl0_reg[7], ctrl0_reg[9],
      ctrl0_reg[11], ctrl0_reg[13], ctrl0_reg[15]}),
    .low_side_enable({ctrl0_reg[4], ctrl0_reg[6], ctrl0_reg[8],
      ctrl0_reg[10], ctrl0_reg[12], ctrl0_reg[14]}),
    .pwm_select(hb_pwm_select),
    .pwm_input_a(pwm_input_a),
    .pwm_input_b(pwm_input_b),
    .allow(allow),
    .drive(hb_next)
  );

  dd_mirror u_mirror (
    .ref_code(ctrl1_reg[`DD_DAC_MSB:`DD_DAC_LSB]),
    .full_scale_select(full_scale_select),
    .mirror_controller_enable(ctrl1_reg[`DD_MIRROR_EN_BIT]),
    .mirror_pulldown_enable(ctrl1_reg[`DD_PULLDOWN_BIT]),
    .pulldown_pwm_select(pulldown_pwm_select),
    .pwm_input_a(pwm_input_a),
    .allow(allow),
    .mirror(mirror_next)
  );

  // Lamp index 0..4 is lamp seven..eleven
  assign lamp_enable[0] = ctrl1_reg[`DD_LAMP_A_MSB] ^ ctrl1_reg[`DD_LAMP_A_LSB];
  assign lamp_enable[1] = ctrl1_reg[`DD_LAMP_B_MSB] ^ ctrl1_reg[`DD_LAMP_B_LSB];
  assign lamp_enable[2] = ctrl1_reg[`DD_LAMP9_BIT];
  assign lamp_enable[3] = ctrl1_reg[`DD_LAMP10_BIT] ||
    ctrl1_reg[`DD_MIRROR_EN_BIT];
  assign lamp_enable[4] = ctrl1_reg[`DD_LAMP11_BIT];

  // Lamps eight and ten on second pin; internal unit for seven to ten
  assign lamp_source[0] = internal_pwm_enable ? internal_pwm : pwm_input_a;
  assign lamp_source[1] = internal_pwm_enable ? internal_pwm : pwm_input_b;
  assign lamp_source[2] = internal_pwm_enable ? internal_pwm : pwm_input_a;
  assign lamp_source[3] = internal_pwm_enable ? internal_pwm : pwm_input_b;
  assign lamp_source[4] = pwm_input_a;

  genvar k;
  generate
    for (k = 0; k < 5; k++) begin : g_lamp
      assign lamp_gate[k] = !lamp_pwm_select[k] || lamp_source[k];
      assign lamp_next.lamp_on[k] = allow && lamp_enable[k] && lamp_gate[k];
    end
  endgenerate

  assign lamp_next.lamp_a_bulb = ctrl1_reg[`DD_LAMP_A_MSB] &&
    !ctrl1_reg[`DD_LAMP_A_LSB];
  assign lamp_next.lamp_b_bulb = ctrl1_reg[`DD_LAMP_B_MSB] &&
    !ctrl1_reg[`DD_LAMP_B_LSB];

  // Output stage registers
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      hb_drive <= '0;
      lamp_drive <= '0;
      mirror_drive <= '0;
      not_ready_flag <= 1'b1;
    end else begin
      hb_drive <= hb_next;
      lamp_drive <= lamp_next;
      mirror_drive <= mirror_next;
      not_ready_flag <= !allow;
    end
  end

  // Assertions
  hb_exclusive_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (hb_drive.high_side_on & hb_drive.low_side_on) == 6'h00)
    else $error("half-bridge both sides on");

  hb_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (allow && ctrl0_reg[15] && !ctrl0_reg[14] && !hb_pwm_select[0])
    |=> hb_drive.high_side_on[0])
    else $error("half-bridge one high side not driven");

  hb_pwm_gate_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (hb_pwm_select[0] && !pwm_input_a) |=> !hb_drive.high_side_on[0] &&
    !hb_drive.low_side_on[0])
    else $error("half-bridge on while pwm low");

  pwm_b_route_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (allow && hb_pwm_select[4] && pwm_input_b && !pwm_input_a &&
    ctrl0_reg[7] && !ctrl0_reg[6]) |=> hb_drive.high_side_on[4])
    else $error("half-bridge five not on second pin");

  mode_active_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == ST_STANDBY && mode_set) |=> state_reg == ST_STARTUP)
    else $error("mode set did not start device");

  standby_clear_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    mode_clear |=> ctrl0_reg == 16'h0000 && ctrl1_reg == 16'h0000 &&
    state_reg == ST_STANDBY ##1 hb_drive == '0 && lamp_drive.lamp_on == 5'h00)
    else $error("standby did not clear");

  lamp_decode_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (ctrl1_reg[15] == ctrl1_reg[14]) |=> !lamp_drive.lamp_on[0])
    else $error("lamp a on with equal mode bits");

  lamp_pwm_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (lamp_pwm_select[4] && !pwm_input_a) |=> !lamp_drive.lamp_on[4])
    else $error("lamp eleven on while pwm low");

  pd_code_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (ctrl1_reg[`DD_DAC_MSB:`DD_DAC_LSB] != 6'h00) |=> !mirror_drive.pulldown_on)
    else $error("pull-down on with nonzero code");

  pd_pwm_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (pulldown_pwm_select && !pwm_input_a) |=> !mirror_drive.pulldown_on)
    else $error("pull-down on while pwm low");

  clamp_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    !full_scale_select |=> mirror_drive.ref_mv <= `DD_CLAMP_MV)
    else $error("mirror voltage above clamp");

  scale_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (full_scale_select && ctrl1_reg[`DD_DAC_MSB:`DD_DAC_LSB] == 6'h3F)
    |=> mirror_drive.ref_mv == 11'h5C4)
    else $error("full scale code wrong voltage");

  pass_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (allow && ctrl1_reg[`DD_MIRROR_EN_BIT]) |=> mirror_drive.pass_transistor_drive)
    else $error("pass transistor drive missing");

  lamp_ten_force_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (allow && ctrl1_reg[`DD_MIRROR_EN_BIT] && !lamp_pwm_select[3])
    |=> lamp_drive.lamp_on[3])
    else $error("lamp ten not forced");

  startup_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == ST_STANDBY && mode_set) |=> !allow [*8] ##1 not_ready_flag)
    else $error("outputs allowed during startup");

  not_ready_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    !allow |=> not_ready_flag)
    else $error("not-ready clear before startup end");

  outputs_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    !allow |=> hb_drive == '0 && lamp_drive.lamp_on == 5'h00 &&
    !mirror_drive.pulldown_on && !mirror_drive.pass_transistor_drive)
    else $error("output on while not active");

  startup_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == ST_STARTUP && startup_reg == STARTUP_CYC - 12'h001 && !mode_clear)
    |=> state_reg == ST_ACTIVE)
    else $error("startup timer did not end");

  mode_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (state_reg == ST_ACTIVE && !mode_clear) |=> state_reg == ST_ACTIVE)
    else $error("active mode lost without clear");

  hb_low_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (allow && !ctrl0_reg[15] && ctrl0_reg[14] && !hb_pwm_select[0])
    |=> hb_drive.low_side_on[0] && !hb_drive.high_side_on[0])
    else $error("half-bridge one low side not driven");

  lamp_bulb_a: assert property (@(posedge clk_sys) disable iff (!rst_n_reg)
    (ctrl1_reg[15:14] == 2'b10) |=> lamp_drive.lamp_a_bulb)
    else $error("lamp a bulb mode not decoded");

  startup_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n_reg)
    state_reg == ST_STARTUP ##1 state_reg == ST_ACTIVE);
  standby_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n_reg)
    state_reg == ST_ACTIVE && mode_clear);
  mirror_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n_reg)
    mirror_drive.pass_transistor_drive && lamp_drive.lamp_on[3]);
  hb_pwm_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n_reg)
    hb_drive.high_side_on[4] && hb_pwm_select[4]);
  pulldown_cover_c: cover property (@(posedge clk_sys) disable iff (!rst_n_reg)
    mirror_drive.pulldown_on);
endmodule

// File: dd_host.sv
module dd_host (
  input wire logic clk_sys,
  input wire logic [15:0] reg_rdata,
  output logic reg_write,
  output logic [3:0] reg_addr,
  output logic [15:0] reg_wdata
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    reg_write = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
  end

  // One word per write, strobe held one edge
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_write = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clk_sys);
    #1;
    reg_write = 1'b0;
    reg_wdata = ~d;
  endtask

  // Read data follows the address of the previous edge
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    #1;
    reg_addr = a;
    @(posedge clk_sys);
    #1;
    d = reg_rdata;
  endtask
endmodule

// File: door_driver_output_control_tb_top.sv
`include "dd_consts.svh"
module door_driver_output_control_tb_top import dd_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_sys, arst_n, reg_write, not_ready_flag, act;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, c0, c1, rv;
  logic pwm_input_a, pwm_input_b, internal_pwm, internal_pwm_enable;
  logic pulldown_pwm_select, full_scale_select;
  logic [5:0] hb_pwm_select;
  logic [4:0] lamp_pwm_select;
  dd_hb_drive_t hb_drive;
  dd_lamp_drive_t lamp_drive;
  dd_mirror_t mirror_drive;
  int fail_count, num_checks;

  dd_top dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .pwm_input_a(pwm_input_a),
    .pwm_input_b(pwm_input_b), .internal_pwm(internal_pwm),
    .internal_pwm_enable(internal_pwm_enable), .hb_pwm_select(hb_pwm_select),
    .lamp_pwm_select(lamp_pwm_select), .pulldown_pwm_select(pulldown_pwm_select),
    .full_scale_select(full_scale_select), .reg_rdata(reg_rdata),
    .hb_drive(hb_drive), .lamp_drive(lamp_drive), .mirror_drive(mirror_drive),
    .not_ready_flag(not_ready_flag));

  dd_host host_u (.clk_sys(clk_sys), .reg_rdata(reg_rdata), .reg_write(reg_write),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask

  // Reference model of every output from shadow registers and pins
  task automatic check_outputs();
    dd_hb_drive_t hb_e;
    dd_lamp_drive_t lp_e;
    logic [4:0] en;
    logic [4:0] src;
    logic g;
    int mv;
    for (int i = 0; i < 6; i++) begin
      g = act & (~hb_pwm_select[i] | ((i == 4) ? pwm_input_b : pwm_input_a));
      hb_e.high_side_on[i] = g & c0[15-2*i] & ~c0[14-2*i];
      hb_e.low_side_on[i] = g & c0[14-2*i] & ~c0[15-2*i];
    end
    chk("hb_drive", 32'(hb_drive), 32'(hb_e));
    en = {c1[9], c1[10] | c1[1], c1[11], ^c1[13:12], ^c1[15:14]};
    src = {pwm_input_a, pwm_input_b, pwm_input_a, pwm_input_b, pwm_input_a};
    if (internal_pwm_enable) begin
      src[3:0] = {4{internal_pwm}};
    end
    lp_e.lamp_on = {5{act}} & en & (~lamp_pwm_select | src);
    lp_e.lamp_a_bulb = c1[15:14] == 2'b10;
    lp_e.lamp_b_bulb = c1[13:12] == 2'b10;
    chk("lamp_drive", 32'(lamp_drive), 32'(lp_e));
    chk("pass_drive", 32'(mirror_drive.pass_transistor_drive), 32'(act & c1[1]));
    g = act & c1[8] & (c1[7:2] == 6'h00) & (~pulldown_pwm_select | pwm_input_a);
    chk("pulldown", 32'(mirror_drive.pulldown_on), 32'(g));
    mv = int'(c1[7:2]) * 1500 / 64;
    if (!full_scale_select && mv > 1200) begin
      mv = 1200;
    end
    if (act) begin
      chk("ref_mv", 32'(mirror_drive.ref_mv), 32'(mv));
    end
    chk("not_ready", 32'(not_ready_flag), 32'(!act));
  endtask

  task automatic check_regs();
    host_u.rd(4'h0, rv);
    chk("ctrl0", 32'(rv), 32'(c0));
    host_u.rd(4'h1, rv);
    chk("ctrl1", 32'(rv), 32'(c1));
    host_u.rd(4'h9, rv);
    chk("unmapped", 32'(rv), 32'h0);
  endtask

  initial begin
    arst_n = 1'b0;
    {pwm_input_a, pwm_input_b, internal_pwm, internal_pwm_enable} = 4'h0;
    {pulldown_pwm_select, full_scale_select, hb_pwm_select, lamp_pwm_select} = 13'h0000;
    fail_count = 0;
    num_checks = 0;
    c0 = 16'h0000;
    c1 = 16'h0000;
    act = 1'b0;
    void'($urandom(24010));
    repeat (12) @(posedge clk_sys);
    #1;
    arst_n = 1'b1;
    idle(3);
    check_outputs();
    check_regs();
    $display("test reset done");
    c1 = 16'h0002;
    host_u.wr(4'h1, c1);
    c0 = 16'h8001;
    host_u.wr(4'h0, c0);
    idle(1990);
    check_outputs();
    idle(12);
    act = 1'b1;
    check_outputs();
    $display("test startup done");
    full_scale_select = 1'b1;
    c1 = 16'h00FC;
    host_u.wr(4'h1, c1);
    idle(3);
    check_outputs();
    full_scale_select = 1'b0;
    idle(3);
    check_outputs();
    $display("test scale done");
    for (int n = 0; n < 200; n++) begin
      {pwm_input_a, pwm_input_b, internal_pwm, internal_pwm_enable, pulldown_pwm_select,
        full_scale_select, hb_pwm_select, lamp_pwm_select} = 17'($urandom);
      c0 = (16'($urandom) & `DD_CTRL0_WMASK) | 16'h0001;
      c1 = 16'($urandom) & `DD_CTRL1_WMASK;
      if ($urandom_range(1, 0) == 1) begin
        c1[7:2] = 6'h00;
      end
      host_u.wr(4'h0, c0);
      host_u.wr(4'h1, c1);
      host_u.wr(4'($urandom_range(15, 2)), 16'hFFFF);
      idle(3);
      check_outputs();
      pwm_input_a = ~pwm_input_a;
      pwm_input_b = ~pwm_input_b;
      internal_pwm = ~internal_pwm;
      idle(3);
      check_outputs();
      check_regs();
    end
    $display("test random done");
    host_u.wr(4'h0, 16'hAAA0);
    c0 = 16'h0000;
    c1 = 16'h0000;
    act = 1'b0;
    idle(3);
    check_outputs();
    check_regs();
    c0 = 16'h0001;
    host_u.wr(4'h0, c0);
    idle(20);
    check_outputs();
    $display("test standby done");
    wrap_up();
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    fail_count++;
    wrap_up();
  end
endmodule
